// ==== hdl/crds_defs.svh ====
// Offsets, field positions, reset values and timing counts of the debounce/shutdown block
`ifndef CRDS_DEFS_SVH
`define CRDS_DEFS_SVH

`define CRDS_OFF_CTRL        8'h00
`define CRDS_OFF_BAT_COUNT   8'h04
`define CRDS_OFF_SDN_COUNT   8'h08
`define CRDS_OFF_IRQ_STATUS  8'h0c
`define CRDS_OFF_IRQ_ENABLE  8'h10
`define CRDS_OFF_IRQ_CLEAR   8'h14
`define CRDS_OFF_SLOT_STATE  8'h18
`define CRDS_OFF_SLOT_REARM  8'h1c

`define CRDS_CTRL_BAT_DET    4
`define CRDS_CTRL_SDN_LEVEL  6
`define CRDS_CTRL_SDN_DET    7
`define CRDS_CTRL_RESET      8'h40

`define CRDS_COUNT_RESET     8'h04

`define CRDS_IRQ_BAT         0
`define CRDS_IRQ_SDN         1
`define CRDS_IRQ_SLOT1_DONE  2
`define CRDS_IRQ_SLOT2_DONE  3
`define CRDS_IRQ_W           4

`define CRDS_SYS_HZ          100000000
`define CRDS_TICK_HZ         32768
`define CRDS_TICK_CYCLES     (`CRDS_SYS_HZ / `CRDS_TICK_HZ)

`endif

// ==== hdl/crds_pkg.sv ====
// Types shared by the debounce/shutdown block
`default_nettype none
package crds_pkg;

   typedef enum logic [2:0] {
      CRDS_SLOT_IDLE    = 3'b000,
      CRDS_SLOT_INSTANT = 3'b001,
      CRDS_SLOT_STAGE_1 = 3'b010,
      CRDS_SLOT_STAGE_2 = 3'b011,
      CRDS_SLOT_STAGE_3 = 3'b100,
      CRDS_SLOT_OFF     = 3'b101
   } crds_slot_state_t;

endpackage : crds_pkg
`default_nettype wire

// ==== hdl/crds_top.sv ====
// Battery/shutdown debounce and card slot automatic shutdown sequencer
`include "crds_defs.svh"
`default_nettype none

module crds_top #(
   parameter int unsigned COUNT_W = 8
) (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [7:0]          reg_rdata,
   input  wire logic                battery_sense_input,
   input  wire logic                shutdown_pin_input,
   input  wire logic [1:0]          slot_powered,
   input  wire logic [1:0]          slot_selected,
   input  wire logic [1:0]          card_clock,
   output logic                     battery_sense_debounced,
   output logic                     shutdown_pin_debounced,
   output logic      [1:0]          slot_reset_force_low,
   output logic      [1:0]          slot_clock_force_low,
   output logic      [1:0]          slot_data_force_low,
   output logic      [1:0]          slot_supply_off,
   output logic                     irq
);

   localparam int unsigned TICK_W = 12;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`CRDS_TICK_CYCLES - 1);

   // Slow timebase: one-cycle enable at the debounce clock rate
   logic [TICK_W-1:0] tick_cnt;
   logic [TICK_W-1:0] next_tick_cnt;
   logic              tick;

   always_comb begin
      tick          = (tick_cnt == TICK_LAST);
      next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // Software registers
   logic [7:0]               ctrl;
   logic [COUNT_W-1:0]       bat_count;
   logic [COUNT_W-1:0]       sdn_count;
   logic [`CRDS_IRQ_W-1:0]   irq_status;
   logic [`CRDS_IRQ_W-1:0]   irq_enable;
   logic [7:0]               next_ctrl;
   logic [COUNT_W-1:0]       next_bat_count;
   logic [COUNT_W-1:0]       next_sdn_count;
   logic [`CRDS_IRQ_W-1:0]   next_irq_status;
   logic [`CRDS_IRQ_W-1:0]   next_irq_enable;
   logic [7:0]               next_reg_rdata;
   logic [`CRDS_IRQ_W-1:0]   irq_events;
   logic [1:0]               rearm;

   // Debouncer channel 0 is battery sense, channel 1 is the shutdown pin
   logic [1:0]               deb_in;
   logic [1:0]               deb_true;
   logic [1:0]               deb_rise;
   logic [1:0]               deb_force;
   logic [1:0]               deb_clear;
   logic [COUNT_W-1:0]       deb_reload [2];
   logic                     sdn_level;
   crds_pkg::crds_slot_state_t slot_state [2];
   logic [1:0]               slot_done;

   assign sdn_level = ctrl[`CRDS_CTRL_SDN_LEVEL];
   assign deb_in[0] = battery_sense_input;
   assign deb_in[1] = (shutdown_pin_input == sdn_level);
   assign deb_reload[0] = bat_count;
   assign deb_reload[1] = sdn_count;
   assign deb_force[0] = 1'b0;
   // Moving the level onto the pin's present state skips the count silently
   assign deb_force[1] = reg_write && (reg_addr == `CRDS_OFF_CTRL)
                         && (reg_wdata[`CRDS_CTRL_SDN_LEVEL] == shutdown_pin_input)
                         && (reg_wdata[`CRDS_CTRL_SDN_LEVEL] != sdn_level);
   // Moving the level away from the pin restarts the count, so no stale true shows
   assign deb_clear[0] = 1'b0;
   assign deb_clear[1] = reg_write && (reg_addr == `CRDS_OFF_CTRL)
                         && (reg_wdata[`CRDS_CTRL_SDN_LEVEL] != shutdown_pin_input)
                         && (reg_wdata[`CRDS_CTRL_SDN_LEVEL] != sdn_level);

   always_comb begin
      next_ctrl       = ctrl;
      next_bat_count  = bat_count;
      next_sdn_count  = sdn_count;
      next_irq_enable = irq_enable;
      rearm           = 2'b00;
      next_reg_rdata  = 8'h00;
      irq_events      = {slot_done[1], slot_done[0], deb_rise[1], deb_rise[0]};
      next_irq_status = irq_status;
      if (reg_write) begin
         case (reg_addr)
            `CRDS_OFF_CTRL:       next_ctrl = reg_wdata;
            `CRDS_OFF_BAT_COUNT:  next_bat_count = reg_wdata[COUNT_W-1:0];
            `CRDS_OFF_SDN_COUNT:  next_sdn_count = reg_wdata[COUNT_W-1:0];
            `CRDS_OFF_IRQ_ENABLE: next_irq_enable = reg_wdata[`CRDS_IRQ_W-1:0];
            `CRDS_OFF_IRQ_CLEAR:  next_irq_status = irq_status & ~reg_wdata[`CRDS_IRQ_W-1:0];
            `CRDS_OFF_SLOT_REARM: rearm = reg_wdata[1:0];
            default:              next_ctrl = ctrl;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_irq_status = next_irq_status | irq_events;
      if (reg_read) begin
         case (reg_addr)
            `CRDS_OFF_CTRL:       next_reg_rdata = ctrl;
            `CRDS_OFF_BAT_COUNT:  next_reg_rdata = 8'(bat_count);
            `CRDS_OFF_SDN_COUNT:  next_reg_rdata = 8'(sdn_count);
            `CRDS_OFF_IRQ_STATUS: next_reg_rdata = 8'(irq_status);
            `CRDS_OFF_IRQ_ENABLE: next_reg_rdata = 8'(irq_enable);
            `CRDS_OFF_SLOT_STATE: next_reg_rdata = {slot_state[1][2:0], slot_state[0][2:0],
                                                   shutdown_pin_debounced,
                                                   battery_sense_debounced};
            default:              next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl       <= `CRDS_CTRL_RESET;
         bat_count  <= COUNT_W'(`CRDS_COUNT_RESET);
         sdn_count  <= COUNT_W'(`CRDS_COUNT_RESET);
         irq_status <= '0;
         irq_enable <= '0;
         reg_rdata  <= 8'h00;
      end else begin
         ctrl       <= next_ctrl;
         bat_count  <= next_bat_count;
         sdn_count  <= next_sdn_count;
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
         reg_rdata  <= next_reg_rdata;
      end
   end

   assign irq = |(irq_status & irq_enable);

   // Debounce counters
   for (genvar d = 0; d < 2; d++) begin : g_deb
      logic [COUNT_W-1:0] cnt;
      logic [COUNT_W-1:0] next_cnt;
      logic               last_in;
      logic               next_last_in;
      logic               next_true;

      always_comb begin
         next_cnt     = cnt;
         next_true    = deb_true[d];
         next_last_in = last_in;
         deb_rise[d]  = 1'b0;
         if (deb_force[d]) begin
            next_cnt     = '0;
            next_true    = 1'b1;
            next_last_in = 1'b1;
         end else if (deb_clear[d]) begin
            next_cnt     = deb_reload[d];
            next_true    = 1'b0;
            next_last_in = 1'b0;
         end else if (tick) begin
            next_last_in = deb_in[d];
            if (!deb_in[d] || (deb_in[d] != last_in)) begin
               // Fresh reload picks up any count written meanwhile
               next_cnt  = deb_reload[d];
               next_true = 1'b0;
            end else if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else begin
               next_true   = 1'b1;
               deb_rise[d] = !deb_true[d];
            end
         end
      end

      always_ff @(posedge clk_sys) begin
         if (reset) begin
            cnt         <= COUNT_W'(`CRDS_COUNT_RESET);
            deb_true[d] <= 1'b0;
            last_in     <= 1'b0;
         end else begin
            cnt         <= next_cnt;
            deb_true[d] <= next_true;
            last_in     <= next_last_in;
         end
      end
   end

   assign battery_sense_debounced = deb_true[0];
   assign shutdown_pin_debounced  = deb_true[1] ? sdn_level : !sdn_level;

   // Shutdown triggers; the pin only reaches the second slot
   logic       bat_start;
   logic       sdn_start;
   logic [1:0] slot_start;

   assign bat_start  = deb_rise[0] && !ctrl[`CRDS_CTRL_BAT_DET];
   assign sdn_start  = deb_rise[1] && !ctrl[`CRDS_CTRL_SDN_DET];
   assign slot_start = {bat_start || sdn_start, bat_start};

   // Slot shutdown sequencers
   for (genvar s = 0; s < 2; s++) begin : g_slot
      crds_pkg::crds_slot_state_t next_state;
      logic [3:0]                 outs;
      logic [3:0]                 next_outs;

      always_comb begin
         next_state   = slot_state[s];
         next_outs    = outs;
         slot_done[s] = 1'b0;
         case (slot_state[s])
            crds_pkg::CRDS_SLOT_IDLE: begin
               next_outs = 4'h0;
               if (slot_start[s]) begin
                  if (slot_powered[s] && slot_selected[s] && card_clock[s]) begin
                     next_outs  = 4'h1;
                     next_state = crds_pkg::CRDS_SLOT_STAGE_1;
                  end else begin
                     next_outs  = 4'h7;
                     next_state = crds_pkg::CRDS_SLOT_INSTANT;
                  end
               end
            end
            // Raw input is no longer looked at once a sequence runs
            crds_pkg::CRDS_SLOT_INSTANT: begin
               if (tick) begin
                  next_outs    = 4'hf;
                  next_state   = crds_pkg::CRDS_SLOT_OFF;
                  slot_done[s] = 1'b1;
               end
            end
            crds_pkg::CRDS_SLOT_STAGE_1: begin
               if (tick) begin
                  next_outs  = 4'h3;
                  next_state = crds_pkg::CRDS_SLOT_STAGE_2;
               end
            end
            crds_pkg::CRDS_SLOT_STAGE_2: begin
               if (tick) begin
                  next_outs  = 4'h7;
                  next_state = crds_pkg::CRDS_SLOT_STAGE_3;
               end
            end
            crds_pkg::CRDS_SLOT_STAGE_3: begin
               if (tick) begin
                  next_outs    = 4'hf;
                  next_state   = crds_pkg::CRDS_SLOT_OFF;
                  slot_done[s] = 1'b1;
               end
            end
            crds_pkg::CRDS_SLOT_OFF: begin
               // Held off until software rearms, so a glitching sense cannot re-power
               if (rearm[s]) begin
                  next_outs  = 4'h0;
                  next_state = crds_pkg::CRDS_SLOT_IDLE;
               end
            end
            default: begin
               next_outs  = 4'hf;
               next_state = crds_pkg::CRDS_SLOT_OFF;
            end
         endcase
      end

      always_ff @(posedge clk_sys) begin
         if (reset) begin
            slot_state[s] <= crds_pkg::CRDS_SLOT_IDLE;
            outs          <= 4'h0;
         end else begin
            slot_state[s] <= next_state;
            outs          <= next_outs;
         end
      end

      assign slot_reset_force_low[s] = outs[0];
      assign slot_clock_force_low[s] = outs[1];
      assign slot_data_force_low[s]  = outs[2];
      assign slot_supply_off[s]      = outs[3];
   end

endmodule : crds_top
`default_nettype wire

// ==== tb/crds_checker.sv ====
// Concurrent checks on the debounce and card slot shutdown block
`include "crds_defs.svh"
`default_nettype none
module crds_checker (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       battery_sense_input,
   input wire logic       battery_sense_debounced,
   input wire logic       shutdown_pin_debounced,
   input wire logic [1:0] slot_reset_force_low,
   input wire logic [1:0] slot_clock_force_low,
   input wire logic [1:0] slot_data_force_low,
   input wire logic [1:0] slot_supply_off,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = `CRDS_TICK_CYCLES;
   logic [7:0]       ctl, next_ctl, en, next_en;
   logic [15:0]      hi, next_hi;
   logic [1:0][15:0] seq, next_seq;
   logic             pin_true;
   assign pin_true = shutdown_pin_debounced == ctl[6];
   // Shadows of the control and enable registers, snooped from the bus
   always_comb begin
      next_ctl = (reg_write && reg_addr == 8'h00) ? reg_wdata : ctl;
      next_en = (reg_write && reg_addr == 8'h10) ? reg_wdata : en;
      next_hi = !battery_sense_input ? 16'h0 : (hi == 16'hffff) ? hi : hi + 16'h1;
      for (int s = 0; s < 2; s++) begin
         next_seq[s] = (slot_reset_force_low[s] && !slot_supply_off[s]) ? seq[s] + 16'h1 : 16'h0;
      end
   end
   always_ff @(posedge clk_sys) begin
      ctl <= reset ? 8'h40 : next_ctl;
      en  <= reset ? 8'h00 : next_en;
      hi  <= reset ? 16'h0 : next_hi;
      seq <= reset ? '0 : next_seq;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_bat_starts_both: assert property ($rose(battery_sense_debounced) && !ctl[4] |->
      ##[0:2] (slot_reset_force_low == 2'b11)) else $error("slots not started");
   a_bat_needs_tick: assert property ($rose(battery_sense_debounced) |-> hi >= TK)
      else $error("battery debounce too early");
   a_irq_on_bat: assert property ($rose(battery_sense_debounced) && en[0] |-> ##[0:1] irq)
      else $error("no battery interrupt");
   a_irq_on_pin: assert property ($rose(pin_true) && $stable(ctl) && en[1] |-> ##[0:1] irq)
      else $error("no pin interrupt");
   a_pin_slot_two: assert property ($rose(pin_true) && $stable(ctl) && !ctl[7] |->
      ##[0:2] slot_reset_force_low[1]) else $error("second slot not started");
   a_supply_last: assert property ((slot_supply_off & ~(slot_reset_force_low &
      slot_clock_force_low & slot_data_force_low)) == 2'b00) else $error("supply off early");
   a_clock_after_rst: assert property ((slot_clock_force_low & ~slot_reset_force_low) == 2'b00)
      else $error("clock forced before reset");
   a_seq_bounded: assert property (seq[0] <= 3 * TK + 2 && seq[1] <= 3 * TK + 2)
      else $error("sequence too long");
   a_seq_no_abort: assert property (($past(slot_reset_force_low) & ~slot_reset_force_low &
      ~$past(slot_supply_off)) == 2'b00) else $error("sequence aborted");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   cover property ($rose(battery_sense_debounced));
   cover property ($rose(slot_clock_force_low[1]) && !slot_data_force_low[1]);
   cover property ($rose(slot_supply_off[1]));
endmodule : crds_checker
bind crds_top crds_checker u_crds_checker (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .battery_sense_input, .battery_sense_debounced, .shutdown_pin_debounced,
   .slot_reset_force_low, .slot_clock_force_low, .slot_data_force_low, .slot_supply_off, .irq);
`default_nettype wire

// ==== tb/crds_card_model.sv ====
// Far side model: slot selection and two cards with their clocks
`default_nettype none
module crds_card_model (
   input  wire logic       clk_sys,
   input  wire logic [1:0] pwr_cmd,
   input  wire logic [1:0] sel_cmd,
   input  wire logic [1:0] run_cmd,
   input  wire logic [1:0] slot_supply_off,
   input  wire logic [1:0] slot_clock_force_low,
   output logic      [1:0] slot_powered,
   output logic      [1:0] slot_selected,
   output logic      [1:0] card_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   // A card loses power with its regulator, and a forced low clock stops it
   always_ff @(posedge clk_sys) begin
      slot_powered  <= pwr_cmd & ~slot_supply_off;
      slot_selected <= sel_cmd;
      card_clock    <= run_cmd & slot_powered & ~slot_clock_force_low;
   end
endmodule : crds_card_model
`default_nettype wire

// ==== tb/crds_top_tb_top.sv ====
// Testbench of the debounce and card slot shutdown block
`include "crds_defs.svh"
`default_nettype none
module crds_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = `CRDS_TICK_CYCLES;
   logic        clk_sys = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0, rd_pend = 1'h0;
   logic        bat = 1'h0, pin = 1'h0, bat_deb, pin_deb, irq;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rnd;
   logic [1:0]  pwr_cmd = 2'h0, sel_cmd = 2'h0, run_cmd = 2'h0;
   logic [1:0]  pwr, sel, cclk, rst_lo, clk_lo, dat_lo, sup;
   logic [7:0]  stg [4] = '{8'h80, 8'ha0, 8'ha8, 8'haa};
   logic [15:0] lfsr = 16'h9c3c;
   logic [7:0]  expq [$];
   int          n_fail = 0, total_checks = 0, cyc = 0;
   initial forever #5 clk_sys = ~clk_sys;
   crds_top u_crds_top (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .battery_sense_input(bat), .shutdown_pin_input(pin), .slot_powered(pwr),
      .slot_selected(sel), .card_clock(cclk), .battery_sense_debounced(bat_deb),
      .shutdown_pin_debounced(pin_deb), .slot_reset_force_low(rst_lo),
      .slot_clock_force_low(clk_lo), .slot_data_force_low(dat_lo), .slot_supply_off(sup), .irq);
   crds_card_model u_crds_card_model (.clk_sys, .pwr_cmd, .sel_cmd, .run_cmd,
      .slot_supply_off(sup), .slot_clock_force_low(clk_lo), .slot_powered(pwr),
      .slot_selected(sel), .card_clock(cclk));
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_step
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      expq.push_back(e);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
   endtask : rd
   // Read data are taken only in the cycle after the strobe
   always @(posedge clk_sys) begin
      rd_pend <= reg_read;
      cyc <= cyc + 1;
      if (rd_pend) chk("reg_rdata", expq.pop_front(), reg_rdata);
      if (cyc == 90000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      rd(`CRDS_OFF_CTRL, 8'h40);
      rd(`CRDS_OFF_BAT_COUNT, 8'h04);
      rd(8'h20, 8'h00);
      wr(`CRDS_OFF_IRQ_ENABLE, 8'h03);
      pwr_cmd <= 2'b11;
      sel_cmd <= 2'b01;
      bat <= 1'b1;
      repeat (2 * TK) @(posedge clk_sys);
      lfsr = lfsr_step(lfsr);
      rnd = lfsr[7:0] | 8'h08;
      wr(`CRDS_OFF_BAT_COUNT, rnd);
      rd(`CRDS_OFF_BAT_COUNT, rnd);
      for (int i = 0; i < 5 * TK && bat_deb !== 1'b1; i++) @(negedge clk_sys);
      chk("battery_sense_debounced", 8'h01, {7'h0, bat_deb});
      @(posedge clk_sys);
      bat <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("slot_outputs", 8'hfc, {rst_lo, clk_lo, dat_lo, sup});
      chk("irq", 8'h01, {7'h0, irq});
      repeat (TK) @(negedge clk_sys);
      chk("slot_outputs", 8'hff, {rst_lo, clk_lo, dat_lo, sup});
      wr(`CRDS_OFF_IRQ_CLEAR, 8'hff);
      wr(`CRDS_OFF_SLOT_REARM, 8'h03);
      repeat (2) @(negedge clk_sys);
      chk("irq_and_supply", 8'h00, {5'h0, irq, sup});
      @(posedge clk_sys);
      sel_cmd <= 2'b11;
      run_cmd <= 2'b10;
      wr(`CRDS_OFF_SDN_COUNT, 8'h02);
      pin <= 1'b1;
      for (int i = 0; i < 5 * TK && pin_deb !== 1'b1; i++) @(negedge clk_sys);
      chk("shutdown_pin_debounced", 8'h01, {7'h0, pin_deb});
      repeat (2) @(negedge clk_sys);
      for (int k = 0; k < 4; k++) begin
         chk("slot_outputs", stg[k], {rst_lo, clk_lo, dat_lo, sup});
         repeat (TK) @(negedge clk_sys);
      end
      chk("irq", 8'h01, {7'h0, irq});
      wr(`CRDS_OFF_IRQ_CLEAR, 8'hff);
      wr(`CRDS_OFF_SLOT_REARM, 8'h02);
      wr(`CRDS_OFF_CTRL, 8'h00);
      run_cmd <= 2'b00;
      pin <= 1'b0;
      // A false spell across a tick must restart the count from the register
      repeat (2 * TK) @(posedge clk_sys);
      pin <= 1'b1;
      repeat (TK + 2) @(posedge clk_sys);
      pin <= 1'b0;
      repeat (2 * TK) @(negedge clk_sys);
      chk("shutdown_pin_debounced", 8'h01, {7'h0, pin_deb});
      for (int i = 0; i < 5 * TK && pin_deb !== 1'b0; i++) @(negedge clk_sys);
      chk("shutdown_pin_debounced", 8'h00, {7'h0, pin_deb});
      repeat (2) @(negedge clk_sys);
      chk("slot_outputs", 8'ha8, {rst_lo, clk_lo, dat_lo, sup});
      conclude();
   end
endmodule : crds_top_tb_top
`default_nettype wire
